// ==== logic/aesf_defs.vh ====
// Constants for the abnormal event status flags block
//----------------------------------------------------------------------
// What this block does
// - Bit 15 reads one whenever any of tx stop, jabber, underflow, rx desc miss, rx stop, rx watchdog, gp timer or fatal bus error is set.
// - Bit 13 sets on a bus parity error, a master abort or a target abort.
// - After a fatal bus error the block withdraws its permission for bus accesses.
// - Bit 11 sets when the general purpose timer expires.
// - Bit 9 sets when the receive watchdog times out.
// - Bit 8 sets when the receive machine enters its stop state.
// - A missing receive descriptor sets bit 7 and suspends reception.
// - Without a poll demand, a newly recognized frame resumes suspended reception.
// - Bit 6 sets each time a frame reception finishes.
// - Bit 5 sets when the transmit FIFO runs empty during transmission.
// - An underflow suspends transmission and writes bit 1 of the first descriptor status word.
// - Writing one to a flag clears it and writing zero leaves it alone.
// - The fatal error cause reads 000 parity, 001 master abort, 010 target abort.
//----------------------------------------------------------------------
`ifndef AESF_DEFS_VH
`define AESF_DEFS_VH

`define AESF_ADDR_W 8
`define AESF_OFF_RX_POLL 8'h10
`define AESF_OFF_EVENT_STATUS 8'h28
`define AESF_RESET_VALUE 32'h00000000

`define AESF_BIT_TX_STOPPED 1
`define AESF_BIT_TX_JABBER 3
`define AESF_BIT_TX_UNDERFLOW 5
`define AESF_BIT_RX_DONE 6
`define AESF_BIT_RX_DESC_UNAVAIL 7
`define AESF_BIT_RX_STOPPED 8
`define AESF_BIT_RX_WATCHDOG 9
`define AESF_BIT_GP_TIMER 11
`define AESF_BIT_FATAL_BUS 13
`define AESF_BIT_ABN_SUMMARY 15
`define AESF_CAUSE_LSB 23

`define AESF_FLAG_MASK 32'h00002BEA
`define AESF_ABN_MASK 32'h00002BAA
`define AESF_CAUSE_PARITY 3'h0
`define AESF_CAUSE_MASTER_ABORT 3'h1
`define AESF_CAUSE_TARGET_ABORT 3'h2
`define AESF_TX_DESC_UNDERFLOW 32'h00000002

`endif

// ==== logic/aesf_sticky_flags.v ====
// Row of sticky event flags with write-one-to-clear
`timescale 1ns/1ns
`default_nettype none

module aesf_sticky_flags #(
    parameter W = 32
) (
    // Clock and reset
    input wire mclk_in,
    input wire rst_in,
    input wire soft_reset_in,
    // Events and clears
    input wire [W-1:0] set_in,
    input wire [W-1:0] clr_in,
    // Flags
    output wire [W-1:0] flags_out
);

    reg [W-1:0] flags_ff;
    wire [W-1:0] nxt_flags;

    // Set wins over a clear in the same cycle
    assign nxt_flags = (flags_ff & ~clr_in) | set_in;

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            flags_ff <= {W{1'b0}};
        end else if (soft_reset_in) begin
            flags_ff <= {W{1'b0}};
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags_out = flags_ff;

endmodule

`default_nettype wire

// ==== logic/aesf_event_status.v ====
// Abnormal event status register with bus-halt and rx/tx suspend control
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "aesf_defs.vh"

module aesf_event_status (
    // Clock and reset
    input wire mclk_in,
    input wire rst_in,
    input wire soft_reset_in,
    // Register port
    input wire [`AESF_ADDR_W-1:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output wire [31:0] reg_rdata_out,
    // Transmit events
    input wire tx_stopped_in,
    input wire tx_jabber_expired_in,
    input wire tx_fifo_empty_in,
    input wire tx_sending_in,
    // Receive events
    input wire rx_frame_done_in,
    input wire rx_desc_miss_in,
    input wire rx_stop_enter_in,
    input wire rx_watchdog_expired_in,
    input wire rx_frame_recognized_in,
    // Timer and bus events
    input wire gp_timer_expired_in,
    input wire bus_parity_err_in,
    input wire bus_master_abort_in,
    input wire bus_target_abort_in,
    // Bus control
    output wire bus_access_ok_out,
    output wire parity_lock_out,
    // Receive control
    output wire rx_suspended_out,
    output wire rx_resume_out,
    output wire rx_fetch_desc_out,
    // Transmit control
    output wire tx_suspend_out,
    output wire tx_desc_status_wr_out,
    output wire [31:0] tx_desc_status_bits_out,
    // Summary
    output wire abnormal_summary_out
);

    //------------------------------------------------------------------
    // Register decode
    //------------------------------------------------------------------
    wire hit_status;
    wire hit_poll;
    wire clr_write;
    wire poll_write;
    wire fatal_event;
    wire underflow_event;
    wire [31:0] set_vec;
    wire [31:0] clr_vec;
    wire [31:0] flags;
    wire abnormal_summary;
    wire fbe_clear;

    // Full-width match; aliases of the two offsets are not decoded
    function addr_hit;
        input [`AESF_ADDR_W-1:0] addr;
        input [`AESF_ADDR_W-1:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    assign hit_status = addr_hit(reg_addr_in, `AESF_OFF_EVENT_STATUS);
    assign hit_poll = addr_hit(reg_addr_in, `AESF_OFF_RX_POLL);
    assign clr_write = reg_wr_in & hit_status;
    assign poll_write = reg_wr_in & hit_poll;

    //------------------------------------------------------------------
    // Event capture
    //------------------------------------------------------------------
    assign fatal_event = bus_parity_err_in | bus_master_abort_in
        | bus_target_abort_in;
    assign underflow_event = tx_fifo_empty_in & tx_sending_in;

    assign set_vec = {
        18'h00000,
        fatal_event,
        1'b0,
        gp_timer_expired_in,
        1'b0,
        rx_watchdog_expired_in,
        rx_stop_enter_in,
        rx_desc_miss_in,
        rx_frame_done_in,
        underflow_event,
        1'b0,
        tx_jabber_expired_in,
        1'b0,
        tx_stopped_in,
        1'b0
    };

    // Only defined flag bits clear; reserved positions ignore writes
    assign clr_vec = clr_write ? (reg_wdata_in & `AESF_FLAG_MASK) : 32'h00000000;

    //------------------------------------------------------------------
    // Flag storage
    //------------------------------------------------------------------
    aesf_sticky_flags #(
        .W(32)
    ) u_flags (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .soft_reset_in(soft_reset_in),
        .set_in(set_vec),
        .clr_in(clr_vec),
        .flags_out(flags)
    );

    //------------------------------------------------------------------
    // Abnormal summary
    //------------------------------------------------------------------
    // Summary follows the flags, so it drops once all are cleared
    assign abnormal_summary = |(flags & `AESF_ABN_MASK);

    //------------------------------------------------------------------
    // Fatal bus error cause and bus halt
    //------------------------------------------------------------------
    reg [2:0] cause_ff;
    reg [2:0] nxt_cause;
    reg bus_halt_ff;
    reg nxt_bus_halt;
    reg parity_lock_ff;
    reg nxt_parity_lock;

    assign fbe_clear = clr_write & reg_wdata_in[`AESF_BIT_FATAL_BUS];

    always @* begin
        nxt_cause = cause_ff;
        // First cause is kept while the flag stands; parity ranks highest
        if (fatal_event && !flags[`AESF_BIT_FATAL_BUS]) begin
            if (bus_parity_err_in) begin
                nxt_cause = `AESF_CAUSE_PARITY;
            end else if (bus_master_abort_in) begin
                nxt_cause = `AESF_CAUSE_MASTER_ABORT;
            end else begin
                nxt_cause = `AESF_CAUSE_TARGET_ABORT;
            end
        end
    end

    always @* begin
        nxt_parity_lock = parity_lock_ff | bus_parity_err_in;
        nxt_bus_halt = bus_halt_ff;
        if (fbe_clear) begin
            // Aborts recover on clear, parity does not
            nxt_bus_halt = parity_lock_ff;
        end
        if (fatal_event) begin
            nxt_bus_halt = 1'b1;
        end
    end

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cause_ff <= `AESF_CAUSE_PARITY;
            bus_halt_ff <= 1'b0;
            parity_lock_ff <= 1'b0;
        end else if (soft_reset_in) begin
            cause_ff <= `AESF_CAUSE_PARITY;
            bus_halt_ff <= 1'b0;
            parity_lock_ff <= 1'b0;
        end else begin
            cause_ff <= nxt_cause;
            bus_halt_ff <= nxt_bus_halt;
            parity_lock_ff <= nxt_parity_lock;
        end
    end

    assign bus_access_ok_out = ~bus_halt_ff;
    assign parity_lock_out = parity_lock_ff;

    //------------------------------------------------------------------
    // Receive suspend and resume
    //------------------------------------------------------------------
    reg rx_susp_ff;
    reg nxt_rx_susp;
    reg rx_resume_ff;
    reg nxt_rx_resume;
    reg rx_fetch_ff;
    reg nxt_rx_fetch;

    always @* begin
        nxt_rx_susp = rx_susp_ff;
        nxt_rx_resume = 1'b0;
        // Device cannot see the own bit; a poll while suspended simply asks for a refetch
        nxt_rx_fetch = poll_write & rx_susp_ff;
        if (rx_susp_ff && (poll_write || rx_frame_recognized_in)) begin
            nxt_rx_susp = 1'b0;
            nxt_rx_resume = 1'b1;
        end
        if (rx_desc_miss_in) begin
            nxt_rx_susp = 1'b1;
            nxt_rx_resume = 1'b0;
        end
    end

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_susp_ff <= 1'b0;
            rx_resume_ff <= 1'b0;
            rx_fetch_ff <= 1'b0;
        end else if (soft_reset_in) begin
            rx_susp_ff <= 1'b0;
            rx_resume_ff <= 1'b0;
            rx_fetch_ff <= 1'b0;
        end else begin
            rx_susp_ff <= nxt_rx_susp;
            rx_resume_ff <= nxt_rx_resume;
            rx_fetch_ff <= nxt_rx_fetch;
        end
    end

    assign rx_suspended_out = rx_susp_ff;
    assign rx_resume_out = rx_resume_ff;
    assign rx_fetch_desc_out = rx_fetch_ff;

    //------------------------------------------------------------------
    // Transmit underflow handling
    //------------------------------------------------------------------
    reg tx_susp_ff;
    reg nxt_tx_susp;
    reg tx_desc_wr_ff;
    reg [31:0] tx_desc_bits_ff;

    always @* begin
        nxt_tx_susp = tx_susp_ff;
        // Suspend ends when the transmit engine leaves its sending phase
        if (!tx_sending_in) begin
            nxt_tx_susp = 1'b0;
        end
        if (underflow_event) begin
            nxt_tx_susp = 1'b1;
        end
    end

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_susp_ff <= 1'b0;
            tx_desc_wr_ff <= 1'b0;
            tx_desc_bits_ff <= 32'h00000000;
        end else if (soft_reset_in) begin
            tx_susp_ff <= 1'b0;
            tx_desc_wr_ff <= 1'b0;
            tx_desc_bits_ff <= 32'h00000000;
        end else begin
            tx_susp_ff <= nxt_tx_susp;
            tx_desc_wr_ff <= underflow_event;
            if (underflow_event) begin
                tx_desc_bits_ff <= `AESF_TX_DESC_UNDERFLOW;
            end
        end
    end

    assign tx_suspend_out = tx_susp_ff;
    assign tx_desc_status_wr_out = tx_desc_wr_ff;
    assign tx_desc_status_bits_out = tx_desc_bits_ff;

    //------------------------------------------------------------------
    // Read path
    //------------------------------------------------------------------
    reg [31:0] rdata_ff;
    reg [31:0] nxt_rdata;
    reg abn_ff;

    always @* begin
        nxt_rdata = rdata_ff;
        if (reg_rd_in) begin
            if (hit_status) begin
                nxt_rdata = flags & `AESF_FLAG_MASK;
                nxt_rdata[`AESF_BIT_ABN_SUMMARY] = abnormal_summary;
                nxt_rdata[`AESF_CAUSE_LSB+2:`AESF_CAUSE_LSB] = cause_ff;
            end else begin
                // Poll register and unmapped offsets read zero
                nxt_rdata = 32'h00000000;
            end
        end
    end

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= `AESF_RESET_VALUE;
            abn_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            abn_ff <= abnormal_summary;
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign abnormal_summary_out = abn_ff;

endmodule

`default_nettype wire

// ==== dv/aesf_event_status_monitor.sv ====
// Assertion checker for the abnormal event status block
`timescale 1ns/1ns
`default_nettype none
`include "aesf_defs.vh"

module aesf_event_status_monitor (
    // Clock, reset and register port
    input wire logic mclk_in, rst_in, soft_reset_in, reg_wr_in, reg_rd_in,
    input wire logic [`AESF_ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_rdata_out,
    // Events
    input wire logic tx_fifo_empty_in, tx_sending_in, rx_desc_miss_in, rx_frame_recognized_in,
    input wire logic gp_timer_expired_in, bus_parity_err_in, bus_master_abort_in,
    input wire logic bus_target_abort_in,
    // Controls and summary
    input wire logic bus_access_ok_out, parity_lock_out, rx_suspended_out, rx_resume_out,
    input wire logic rx_fetch_desc_out, tx_suspend_out, tx_desc_status_wr_out,
    input wire logic abnormal_summary_out,
    input wire logic [31:0] tx_desc_status_bits_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // Soft reset in the same cycle wins, so it is kept out of every cause whose outcome it clears
    wire poll_wr = reg_wr_in && (reg_addr_in == `AESF_OFF_RX_POLL) && !soft_reset_in;
    sequence bus_fault_s;
        (bus_parity_err_in || bus_master_abort_in || bus_target_abort_in) && !soft_reset_in;
    endsequence
    sequence abn_event_s;
        ((gp_timer_expired_in || rx_desc_miss_in) && !soft_reset_in)
            ##1 (!reg_wr_in && !soft_reset_in);
    endsequence
    AST_BUS_HALT: assert property (bus_fault_s |=> !bus_access_ok_out)
        else $error("bus access still allowed after fatal error");
    AST_PARITY_HOLD: assert property (parity_lock_out && !soft_reset_in |=> parity_lock_out)
        else $error("parity lock dropped without soft reset");
    AST_PARITY_NO_BUS: assert property (parity_lock_out |-> !bus_access_ok_out)
        else $error("bus access allowed under parity lock");
    AST_RX_SUSPEND: assert property (rx_desc_miss_in && !soft_reset_in |=> rx_suspended_out)
        else $error("rx not suspended after descriptor miss");
    AST_RX_POLL: assert property (poll_wr && rx_suspended_out && !rx_desc_miss_in |=>
        rx_resume_out && rx_fetch_desc_out && !rx_suspended_out) else $error("poll did not resume");
    AST_RX_FRAME: assert property (rx_frame_recognized_in && rx_suspended_out && !poll_wr
        && !rx_desc_miss_in && !soft_reset_in |=> rx_resume_out ##1 !rx_resume_out)
        else $error("frame did not resume rx with one pulse");
    AST_TX_UNDERFLOW: assert property (tx_fifo_empty_in && tx_sending_in
        && !soft_reset_in |=> tx_suspend_out && tx_desc_status_wr_out
        && tx_desc_status_bits_out == `AESF_TX_DESC_UNDERFLOW)
        else $error("underflow side effects missing");
    AST_SUMMARY_OUT: assert property (abn_event_s |=> abnormal_summary_out)
        else $error("summary output not raised");
    AST_SUMMARY_BIT: assert property (reg_rd_in && reg_addr_in == `AESF_OFF_EVENT_STATUS |=>
        reg_rdata_out[15] == |(reg_rdata_out & `AESF_ABN_MASK)) else $error("summary bit wrong");
endmodule

bind aesf_event_status aesf_event_status_monitor u_mon (
    .mclk_in(mclk_in), .rst_in(rst_in), .soft_reset_in(soft_reset_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_rdata_out(reg_rdata_out),
    .tx_fifo_empty_in(tx_fifo_empty_in), .tx_sending_in(tx_sending_in),
    .rx_desc_miss_in(rx_desc_miss_in), .rx_frame_recognized_in(rx_frame_recognized_in),
    .gp_timer_expired_in(gp_timer_expired_in), .bus_parity_err_in(bus_parity_err_in),
    .bus_master_abort_in(bus_master_abort_in), .bus_target_abort_in(bus_target_abort_in),
    .bus_access_ok_out(bus_access_ok_out), .parity_lock_out(parity_lock_out),
    .rx_suspended_out(rx_suspended_out), .rx_resume_out(rx_resume_out),
    .rx_fetch_desc_out(rx_fetch_desc_out), .tx_suspend_out(tx_suspend_out),
    .tx_desc_status_wr_out(tx_desc_status_wr_out), .abnormal_summary_out(abnormal_summary_out),
    .tx_desc_status_bits_out(tx_desc_status_bits_out)
);
`default_nettype wire

// ==== dv/tb_abnormal_event_status_flags.sv ====
// Self-checking testbench for the abnormal event status block
`timescale 1ns/1ns
`default_nettype none
`include "aesf_defs.vh"

module tb_abnormal_event_status_flags;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic soft_reset_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic rd_seen = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic [31:0] lfsr = 32'hD8922743;
    logic [31:0] exp_q[$];
    logic [12:0] ev = 13'h0;
    wire [31:0] rdata, bits;
    wire ok, lock, rx_susp, rx_res, rx_fetch, tx_susp, desc_wr, summ;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    int fb[8] = '{1, 3, 5, 6, 7, 8, 9, 11};
    logic [12:0] evm[8] = '{13'h001, 13'h002, 13'h00C, 13'h010, 13'h020, 13'h040, 13'h080, 13'h200};
    logic [31:0] f;
    logic [31:0] e;

    aesf_event_status uut (
        .mclk_in(mclk_in), .rst_in(rst_in), .soft_reset_in(soft_reset_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .tx_stopped_in(ev[0]),
        .tx_jabber_expired_in(ev[1]), .tx_fifo_empty_in(ev[2]), .tx_sending_in(ev[3]),
        .rx_frame_done_in(ev[4]), .rx_desc_miss_in(ev[5]), .rx_stop_enter_in(ev[6]),
        .rx_watchdog_expired_in(ev[7]), .rx_frame_recognized_in(ev[8]),
        .gp_timer_expired_in(ev[9]), .bus_parity_err_in(ev[10]), .bus_master_abort_in(ev[11]),
        .bus_target_abort_in(ev[12]), .bus_access_ok_out(ok), .parity_lock_out(lock),
        .rx_suspended_out(rx_susp), .rx_resume_out(rx_res), .rx_fetch_desc_out(rx_fetch),
        .tx_suspend_out(tx_susp), .tx_desc_status_wr_out(desc_wr),
        .tx_desc_status_bits_out(bits), .abnormal_summary_out(summ)
    );

    always #20 mclk_in = ~mclk_in;

    function automatic logic [31:0] nxt_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, ex, got);
        end
    endtask

    // All drivers end mid-cycle so callers sample settled outputs
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        @(negedge mclk_in);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        exp_q.push_back(ex);
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        @(negedge mclk_in);
    endtask

    task automatic pulse(input logic [12:0] m, input logic sr);
        @(posedge mclk_in);
        ev <= m;
        soft_reset_in <= sr;
        @(posedge mclk_in);
        ev <= 13'h0;
        soft_reset_in <= 1'b0;
        @(negedge mclk_in);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Read data appears in the cycle after the strobe and is checked there; it holds until the next read
    always @(posedge mclk_in) rd_seen <= reg_rd_in;
    always @(negedge mclk_in) begin
        if (rd_seen) begin
            chk("status read", exp_q.pop_front(), rdata);
        end
    end

    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(negedge mclk_in);
        chk("bus ok at reset", 32'h1, {31'h0, ok});
        rd(`AESF_OFF_EVENT_STATUS, `AESF_RESET_VALUE);
        rd(8'h3C, 32'h0);
        for (int i = 0; i < 8; i++) begin
            pulse(evm[i], 1'b0);
            f = 32'h1 << fb[i];
            e = f | (((f & `AESF_ABN_MASK) != 0) ? 32'h8000 : 32'h0);
            rd(`AESF_OFF_EVENT_STATUS, e);
            wr(`AESF_OFF_EVENT_STATUS, lfsr & ~f);
            rd(`AESF_OFF_EVENT_STATUS, e);
            wr(`AESF_OFF_EVENT_STATUS, f);
            rd(`AESF_OFF_EVENT_STATUS, 32'h0);
            lfsr = nxt_rand(lfsr);
        end
        $display("test flags done");
        chk("rx suspended", 32'h1, {31'h0, rx_susp});
        wr(`AESF_OFF_RX_POLL, lfsr);
        chk("poll resume", 32'h3, {30'h0, rx_res, rx_fetch});
        chk("poll unsuspend", 32'h0, {31'h0, rx_susp});
        pulse(13'h020, 1'b0);
        pulse(13'h100, 1'b0);
        chk("frame resume", 32'h2, {30'h0, rx_res, rx_fetch});
        pulse(13'h00C, 1'b0);
        chk("tx underflow", 32'h3, {30'h0, tx_susp, desc_wr});
        chk("tx desc bits", `AESF_TX_DESC_UNDERFLOW, bits);
        $display("test rx tx done");
        for (int i = 0; i < 3; i++) begin
            pulse(13'h0, 1'b1);
            pulse(13'h400 << i, 1'b0);
            chk("bus halted", 32'h0, {31'h0, ok});
            rd(`AESF_OFF_EVENT_STATUS, 32'hA000 | (i << `AESF_CAUSE_LSB));
            chk("summary out", 32'h1, {31'h0, summ});
            wr(`AESF_OFF_EVENT_STATUS, 32'h2000);
            @(negedge mclk_in);
            chk("bus after clear", (i != 0), {31'h0, ok});
            chk("parity lock", (i == 0), {31'h0, lock});
        end
        pulse(13'h0, 1'b1);
        chk("bus after soft reset", 32'h1, {31'h0, ok});
        $display("test fatal done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
